// ===== spm_pkg.sv
// Purpose: shared constants and types for the serial master/slave port
// Assumes: one core clock, all pins sampled as synchronous inputs
// Notes:   rate select picks one of six master serial clock dividers
// Operation
// - full duplex on three lines, simplex on two lines
// - port works as master or slave, never multi-master
// - six master clock rates, fastest is core clock over four
// - serial clock driven as master, received as slave
// - bytes shift most significant bit first
// - every transfer is started by the master
// - slave shifts back data while master shifts out, same clock
// - data lines tied together give one-direction simplex only
// - four clock polarity/phase modes, both ends set alike
// - control bit picks pin or software for internal select
// - software mode frees select pin, level from software bit
// - first-edge slave reload without select rise flags collision
// - transfer complete flag with irq, collision, fault, overrun
// - unselected slave must not drive shared data lines
// - data write loads shift register, shifted out msb first
// - complete flag set at byte end, blocks writes until read
// - select low in master mode sets fault, clears enables
// - write during transfer discarded, sets collision, no irq
package spm_pkg;
   localparam int          SPM_BYTE_W   = 8;
   localparam int          SPM_RATE_CNT = 6;
   localparam logic [2:0]  SPM_RATE_RST = 3'h0;
   localparam logic [7:0]  SPM_DATA_RST = 8'h00;
   localparam int          SPM_DIV_W    = 8;
   localparam int          SPM_MIN_DIV  = 4;
   // half-period counts in core cycles for the six rates (full = 2x)
   localparam logic [7:0]  SPM_HALF_TBL [SPM_RATE_CNT] =
      '{8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40};
   typedef enum logic [1:0] {
      SPM_IDLE  = 2'b00,
      SPM_SHIFT = 2'b01,
      SPM_DONE  = 2'b11
   } spm_state_t;
endpackage

// ===== spm_edge_if.sv
`timescale 1ns/100ps
// Purpose: carries serial clock edge events from the edge unit
// Assumes: single core clock
// Notes:   lead edge shifts out in phase 1, sample edge captures
interface spm_edge_if;
   logic lead;
   logic trail;
   modport src (output lead, output trail);
   modport dst (input lead, input trail);
endinterface

// ===== spm_edge.sv
`timescale 1ns/100ps
// Purpose: detects edges of the sampled serial clock input
// Assumes: external clock no faster than core over two
// Notes:   registered history, so each edge is one pulse late
module spm_edge
   import spm_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic nrst,
   input  wire logic sck_in,
   input  wire logic idle_pol,
   spm_edge_if.src   ev
);
   logic sck_ff, nxt_sck;
   logic lead_ff, nxt_lead, trail_ff, nxt_trail;
   logic prim_ff, nxt_prim;
   // lead edge leaves idle level, trail edge returns to it
   // history holds zero after reset, so no edge until primed
   always_comb begin
      nxt_sck   = sck_in;
      nxt_prim  = 1'b1;
      nxt_lead  = prim_ff && (sck_ff == idle_pol) && (sck_in != idle_pol);
      nxt_trail = prim_ff && (sck_ff != idle_pol) && (sck_in == idle_pol);
   end
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sck_ff   <= 1'b0;
         prim_ff  <= 1'b0;
         lead_ff  <= 1'b0;
         trail_ff <= 1'b0;
      end else begin
         sck_ff   <= nxt_sck;
         prim_ff  <= nxt_prim;
         lead_ff  <= nxt_lead;
         trail_ff <= nxt_trail;
      end
   end
   assign ev.lead  = lead_ff;
   assign ev.trail = trail_ff;
endmodule

// ===== spm_port.sv
`timescale 1ns/100ps
// Purpose: byte-wide serial port, master or slave, four clock modes
// Assumes: pins synchronous to sys_clk; slave clock under core over two
// Notes:   status read clears overrun; then data read clears complete and collision, control write clears fault
module spm_port
   import spm_pkg::*;
#(
   parameter int BYTE_W = SPM_BYTE_W
)
(
   input  wire logic              sys_clk,
   input  wire logic              nrst,
   input  wire logic              serial_port_enable,
   input  wire logic              master_select,
   input  wire logic              ctrl_wr,
   input  wire logic              clk_pol,
   input  wire logic              clk_pha,
   input  wire logic [2:0]        rate_sel,
   input  wire logic              slave_select_software_mode,
   input  wire logic              internal_select_level,
   input  wire logic              data_wr,
   input  wire logic [BYTE_W-1:0] data_wdata,
   input  wire logic              data_rd,
   input  wire logic              status_rd,
   input  wire logic              transfer_irq_enable,
   input  wire logic              sck_in,
   input  wire logic              miso_in,
   input  wire logic              mosi_in,
   input  wire logic              ss_n_in,
   output logic                   sck_out,
   output logic                   sck_oe,
   output logic                   miso_out,
   output logic                   miso_oe,
   output logic                   mosi_out,
   output logic                   mosi_oe,
   output logic [BYTE_W-1:0]      data_rdata,
   output logic                   transfer_complete_flag,
   output logic                   write_collision_flag,
   output logic                   master_fault_flag,
   output logic                   overrun_flag,
   output logic                   port_enabled,
   output logic                   master_active,
   output logic                   busy,
   output logic                   irq
);
   spm_edge_if ev ();
   spm_state_t        st_ff, nxt_st;
   logic [BYTE_W-1:0] sh_ff, nxt_sh, rx_ff, nxt_rx;
   logic [3:0]        bit_ff, nxt_bit;
   logic [7:0]        div_ff, nxt_div;
   logic              sck_ff, nxt_sck, out_ff, nxt_out;
   logic              en_ff, nxt_en, mst_ff, nxt_mst;
   logic              tcf_ff, nxt_tcf, write_collision_flag_ff, nxt_write_collision_flag;
   logic              master_fault_flag_ff, nxt_master_fault_flag, ovr_ff, nxt_ovr;
   logic              seen_ff, nxt_seen;
   logic              busy_ff, nxt_busy, mdrv_ff, nxt_mdrv;
   logic              selrise_ff, nxt_selrise;
   logic              irq_ff, nxt_irq;
   logic              ss_int, lead, trail, samp, shft, half, wr_ok;
   logic [7:0]        half_cnt;

   // internal select from pin or software level bit
   assign ss_int = slave_select_software_mode ? internal_select_level
                                              : ss_n_in;
   // slave clocks come from the edge unit
   spm_edge spm_edge_inst (
      .sys_clk  (sys_clk),
      .nrst     (nrst),
      .sck_in   (sck_in),
      .idle_pol (clk_pol),
      .ev       (ev.src)
   );
   // rate table, six entries, out-of-range codes use the slowest
   assign half_cnt = (rate_sel < 3'(SPM_RATE_CNT)) ? SPM_HALF_TBL[rate_sel]
                                                   : SPM_HALF_TBL[5];
   assign half  = (div_ff == half_cnt - 8'h01);
   assign lead  = mst_ff ? (st_ff == SPM_SHIFT && half && sck_ff == clk_pol)
                         : (ev.lead && !ss_int);
   assign trail = mst_ff ? (st_ff == SPM_SHIFT && half && sck_ff != clk_pol)
                         : (ev.trail && !ss_int);
   // phase picks sample and shift edges
   assign samp  = clk_pha ? trail : lead;
   assign shft  = clk_pha ? lead : trail;
   // writes refused while complete flag unread
   assign wr_ok = data_wr && !(tcf_ff && !seen_ff);

   // transfer engine and flags
   always_comb begin
      nxt_st      = st_ff;
      nxt_sh      = sh_ff;
      nxt_rx      = rx_ff;
      nxt_bit     = bit_ff;
      nxt_div     = div_ff;
      nxt_sck     = sck_ff;
      nxt_out     = out_ff;
      nxt_en      = en_ff;
      nxt_mst     = mst_ff;
      nxt_tcf     = tcf_ff;
      nxt_write_collision_flag    = write_collision_flag_ff;
      nxt_master_fault_flag    = master_fault_flag_ff;
      nxt_ovr     = ovr_ff;
      nxt_seen    = seen_ff;
      nxt_selrise = selrise_ff | ss_int;
      nxt_irq     = 1'b0;
      // enables only taken when no fault pending or after a status read
      if (ctrl_wr && (!master_fault_flag_ff || seen_ff)) begin
         nxt_en  = serial_port_enable;
         nxt_mst = master_select;
         if (master_fault_flag_ff) nxt_master_fault_flag = 1'b0;
      end
      // status read arms clearing; overrun clears on read
      if (status_rd) begin
         nxt_seen = tcf_ff | master_fault_flag_ff | write_collision_flag_ff;
         nxt_ovr  = 1'b0;
      end
      if (data_rd && seen_ff) begin
         nxt_tcf  = 1'b0;
         nxt_write_collision_flag = 1'b0;
         nxt_seen = 1'b0;
      end
      // data write: load or collide
      if (wr_ok && en_ff) begin
         if (st_ff == SPM_SHIFT ||
             (!mst_ff && !clk_pha && !ss_int && !selrise_ff)) begin
            nxt_write_collision_flag = 1'b1;
         end else begin
            nxt_sh      = data_wdata;
            nxt_selrise = 1'b0;
            nxt_out    = data_wdata[BYTE_W-1];
            nxt_bit    = 4'h0;
            // master starts, slave waits for clock
            if (mst_ff) begin
               nxt_st  = SPM_SHIFT;
               nxt_div = 8'h00;
            end
         end
      end
      // divider also runs in done, so the last half period completes
      if (mst_ff && st_ff != SPM_IDLE) begin
         nxt_div = half ? 8'h00 : div_ff + 8'h01;
         if (half) nxt_sck = ~sck_ff;
      end
      // slave enters shifting on a leading edge only
      // the closing trail of a first-edge byte must not restart it
      if (!mst_ff && en_ff && st_ff == SPM_IDLE && lead)
         nxt_st = SPM_SHIFT;
      // msb-first shifting
      if (samp && en_ff) begin
         nxt_sh  = {sh_ff[BYTE_W-2:0], mst_ff ? miso_in : mosi_in};
         nxt_bit = bit_ff + 4'h1;
         if (bit_ff == 4'(BYTE_W-1)) nxt_st = SPM_DONE;
      end
      if (shft && en_ff && !(clk_pha && bit_ff == 4'h0 && !mst_ff))
         nxt_out = sh_ff[BYTE_W-1];
      if (clk_pha && lead && bit_ff == 4'h0) nxt_out = sh_ff[BYTE_W-1];
      // byte end sets complete or overrun
      if (st_ff == SPM_DONE && (!mst_ff || half || sck_ff == clk_pol)) begin
         nxt_st     = SPM_IDLE;
         nxt_sck    = clk_pol;
         nxt_bit    = 4'h0;
         nxt_selrise = 1'b0; // select must rise before next load
         nxt_rx     = sh_ff;
         if (tcf_ff) begin
            nxt_ovr = 1'b1;
            nxt_rx  = rx_ff;
         end
         nxt_tcf = 1'b1;
         nxt_irq = transfer_irq_enable;
      end
      // select low in master mode is a fault
      if (mst_ff && en_ff && !ss_int) begin
         nxt_master_fault_flag = 1'b1;
         nxt_en   = 1'b0;
         nxt_mst  = 1'b0;
         nxt_st   = SPM_IDLE;
         nxt_sck  = clk_pol;
         nxt_irq  = transfer_irq_enable;
      end
      if (!nxt_en) nxt_st = SPM_IDLE;
      if (!mst_ff) nxt_sck = clk_pol;
      // clock and mosi drives and busy registered so those outputs come from flops
      nxt_busy = (nxt_st != SPM_IDLE);
      nxt_mdrv = nxt_en & nxt_mst;
   end

   // state registers; select-rise starts set so the first load is clean
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         st_ff      <= SPM_IDLE;
         sh_ff      <= SPM_DATA_RST;
         rx_ff      <= SPM_DATA_RST;
         bit_ff     <= 4'h0;
         div_ff     <= 8'h00;
         sck_ff     <= 1'b0;
         out_ff     <= 1'b0;
         en_ff      <= 1'b0;
         mst_ff     <= 1'b0;
         tcf_ff     <= 1'b0;
         write_collision_flag_ff    <= 1'b0;
         master_fault_flag_ff    <= 1'b0;
         ovr_ff     <= 1'b0;
         seen_ff    <= 1'b0;
         selrise_ff <= 1'b1;
         irq_ff     <= 1'b0;
         busy_ff    <= 1'b0;
         mdrv_ff    <= 1'b0;
      end else begin
         st_ff      <= nxt_st;
         sh_ff      <= nxt_sh;
         rx_ff      <= nxt_rx;
         bit_ff     <= nxt_bit;
         div_ff     <= nxt_div;
         sck_ff     <= nxt_sck;
         out_ff     <= nxt_out;
         en_ff      <= nxt_en;
         mst_ff     <= nxt_mst;
         tcf_ff     <= nxt_tcf;
         write_collision_flag_ff    <= nxt_write_collision_flag;
         master_fault_flag_ff    <= nxt_master_fault_flag;
         ovr_ff     <= nxt_ovr;
         seen_ff    <= nxt_seen;
         selrise_ff <= nxt_selrise;
         irq_ff     <= nxt_irq;
         busy_ff    <= nxt_busy;
         mdrv_ff    <= nxt_mdrv;
      end
   end

   // pins: master drives clock and mosi; selected slave drives miso
   // simplex wiring works since only the active end enables
   always_comb begin
      sck_out  = sck_ff;
      sck_oe   = mdrv_ff;
      mosi_out = out_ff;
      mosi_oe  = mdrv_ff;
      miso_out = out_ff;
      miso_oe  = en_ff & ~mst_ff & ~ss_int;
      data_rdata             = rx_ff;
      transfer_complete_flag = tcf_ff;
      write_collision_flag   = write_collision_flag_ff;
      master_fault_flag      = master_fault_flag_ff;
      overrun_flag           = ovr_ff;
      port_enabled           = en_ff;
      master_active          = mst_ff;
      busy                   = busy_ff;
      irq                    = irq_ff;
   end
endmodule

// ===== spm_checker.sv
// Purpose: port-level assertions for the serial port
// Assumes: one clock domain, nrst asynchronous active low
// Notes:   bound onto spm_port at the foot of this file
`timescale 1ns/100ps
module spm_checker
   import spm_pkg::*;
#(
   parameter int BYTE_W = SPM_BYTE_W
)
(
   input wire logic       sys_clk,
   input wire logic       nrst,
   input wire logic       data_wr,
   input wire logic       transfer_irq_enable,
   input wire logic       slave_select_software_mode,
   input wire logic       internal_select_level,
   input wire logic       ss_n_in,
   input wire logic [2:0] rate_sel,
   input wire logic       sck_oe,
   input wire logic       miso_oe,
   input wire logic       mosi_oe,
   input wire logic       transfer_complete_flag,
   input wire logic       write_collision_flag,
   input wire logic       master_fault_flag,
   input wire logic       port_enabled,
   input wire logic       master_active,
   input wire logic       busy,
   input wire logic       irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   logic [7:0] busy_cnt_ff;
   logic [7:0] nxt_busy_cnt;
   // length of the current busy stretch, too long for a repetition
   always_comb nxt_busy_cnt = busy ? busy_cnt_ff + 8'h01 : 8'h00;
   always_ff @(posedge sys_clk or negedge nrst)
      if (!nrst) busy_cnt_ff <= 8'h00;
      else busy_cnt_ff <= nxt_busy_cnt;

   a_irq_pulse: assert property (irq |=> !irq)
      else $error("irq wider than one cycle");
   a_irq_enable: assert property (irq |->
      transfer_irq_enable || $past(transfer_irq_enable))
      else $error("irq while disabled");
   a_irq_cause: assert property (irq |->
      ##[0:1] (transfer_complete_flag || master_fault_flag))
      else $error("irq without flag");
   a_write_collision_flag_quiet: assert property (
      $rose(write_collision_flag) |-> !irq)
      else $error("collision raised irq");
   a_write_collision_flag_cause: assert property (
      $rose(write_collision_flag) |-> $past(data_wr))
      else $error("collision without write");
   a_done_cause: assert property (
      $rose(transfer_complete_flag) && master_active |-> $past(busy))
      else $error("complete without transfer");
   a_fault_drop: assert property ($rose(master_fault_flag) |->
      ##[0:1] (!port_enabled && !master_active))
      else $error("fault left port enabled");
   a_fault_cause: assert property ($rose(master_fault_flag) |->
      $past(master_active))
      else $error("fault outside master mode");
   a_sck_drive: assert property (sck_oe |->
      master_active || $past(master_active))
      else $error("clock driven as slave");
   // effective select is the software level when software mode is on
   a_slave_quiet: assert property (!master_active &&
      (slave_select_software_mode ? internal_select_level : ss_n_in)
      |-> !miso_oe)
      else $error("deselected slave drives data");
   a_mosi_drive: assert property (
      busy && master_active |-> mosi_oe)
      else $error("master data line not driven");
   a_byte_len: assert property ($fell(busy) && master_active
      && rate_sel == 3'h0 |-> busy_cnt_ff inside {[8'h1f:8'h21]})
      else $error("master byte length wrong");
endmodule
bind spm_port spm_checker #(.BYTE_W(BYTE_W)) spm_checker_inst (.*);

// ===== spm_slave_model.sv
// Purpose: far-end slave for master-mode traffic
// Assumes: clock mode 0, idle low, capture on rising clock
// Notes:   data line has no pull, so released shows inverse
`timescale 1ns/100ps
module spm_slave_model (
   input  wire logic       sck,
   input  wire logic       mosi,
   input  wire logic       sel_n,
   input  wire logic       load,
   input  wire logic [7:0] tx_byte,
   output logic            miso,
   output logic [7:0]      rx_byte
);
   logic [7:0] sh;
   // capture on rising clock; never starts a frame itself
   always @(posedge sck) rx_byte <= {rx_byte[6:0], mosi};
   // next bit on falling clock, loaded only between frames
   always @(posedge load or negedge sck)
      if (load) sh <= tx_byte;
      else sh <= {sh[6:0], ~sh[0]};
   // deselected: inverse of last bit, never a held value
   assign miso = sel_n ? ~sh[7] : sh[7];
endmodule

// ===== spm_port_tb.sv
// Purpose: self-checking bench for the serial port
// Assumes: inputs change on falling clock edges
// Notes:   bench plays the external master in slave tests
`timescale 1ns/100ps
module spm_port_tb;
   import spm_pkg::*;
   logic sys_clk = 0, nrst = 0, serial_port_enable = 0, master_select = 0;
   logic ctrl_wr = 0, clk_pol = 0, clk_pha = 0, data_wr = 0, data_rd = 0;
   logic status_rd = 0, transfer_irq_enable = 1, ss_n_in = 1;
   logic slave_select_software_mode = 0, internal_select_level = 0;
   logic m_sck = 0, m_mosi = 0, p_sel_n = 1, p_load = 0;
   logic [2:0] rate_sel = 3'h0;
   logic [7:0] data_wdata = 8'h00, p_tx = 8'h00, p_rx, data_rdata;
   logic sck_out, sck_oe, miso_out, miso_oe, mosi_out, mosi_oe, p_miso;
   logic transfer_complete_flag, write_collision_flag, master_fault_flag;
   logic overrun_flag, port_enabled, master_active, busy, irq;
   wire  sck_in = sck_oe ? sck_out : m_sck;
   wire  mosi_in = mosi_oe ? mosi_out : m_mosi;
   wire  miso_in = miso_oe ? miso_out : p_miso;
   int   n_errors = 0, n_tests = 0, cyc = 0, n_irq = 0;

   spm_port #(.BYTE_W(8)) spm_port_inst (.*);
   spm_slave_model spm_slave_model_inst (.sck(sck_in), .mosi(mosi_in),
      .sel_n(p_sel_n), .load(p_load), .tx_byte(p_tx), .miso(p_miso),
      .rx_byte(p_rx));

   always #10 sys_clk = ~sys_clk;
   // cycle ceiling against hangs, and an irq pulse count
   always @(posedge sys_clk) begin
      cyc++;
      if (irq === 1'b1) n_irq++;
      if (cyc == 6000) begin
         n_errors++;
         summarize();
      end
   end

   task automatic chk(input string nm, input logic [7:0] e, g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] d);
      data_wdata = d;
      data_wr = 1;
      @(negedge sys_clk) data_wr = 0;
   endtask
   task automatic ctl(input logic e, m);
      serial_port_enable = e;
      master_select = m;
      ctrl_wr = 1;
      @(negedge sys_clk) ctrl_wr = 0;
   endtask
   // status read then data read clears the byte flags
   task automatic clr;
      status_rd = 1;
      @(negedge sys_clk) status_rd = 0;
      data_rd = 1;
      @(negedge sys_clk) data_rd = 0;
   endtask
   task automatic wait_idle;
      repeat (2) @(negedge sys_clk);
      for (int k = 0; busy !== 1'b0 && k < 2000; k++) @(negedge sys_clk);
      repeat (2) @(negedge sys_clk);
   endtask

   task automatic t_master;
      p_tx = 8'h3c;
      p_load = 1;
      p_sel_n = 0;
      @(negedge sys_clk) p_load = 0;
      slave_select_software_mode = 1;
      internal_select_level = 1;
      ss_n_in = 0;
      ctl(1'h1, 1'h1);
      n_irq = 0;
      wr(8'ha5);
      repeat (6) @(negedge sys_clk);
      chk("sck_oe", 8'h01, sck_oe);
      wr(8'h5a);
      @(negedge sys_clk);
      chk("write_collision_flag", 8'h01, write_collision_flag);
      wait_idle();
      chk("done", 8'h01, transfer_complete_flag);
      chk("rdata", 8'h3c, data_rdata);
      chk("p_rx", 8'ha5, p_rx);
      chk("n_irq", 8'h01, n_irq[7:0]);
      wr(8'h11);
      @(negedge sys_clk);
      chk("busy", 8'h00, busy);
      clr();
      chk("flags", 8'h00, {transfer_complete_flag, write_collision_flag,
         master_fault_flag});
      ss_n_in = 1;
      $display("test master done");
   endtask

   task automatic t_rates;
      logic s;
      int k;
      for (int r = 0; r < SPM_RATE_CNT; r++) begin
         rate_sel = r[2:0];
         wr(8'h00);
         s = sck_out;
         for (k = 0; sck_out === s && k < 300; k++) @(negedge sys_clk);
         s = sck_out;
         for (k = 0; sck_out === s && k < 300; k++) @(negedge sys_clk);
         chk("half", SPM_HALF_TBL[r], k[7:0]);
         wait_idle();
         clr();
      end
      $display("test rates done");
   endtask

   task automatic t_fault;
      ss_n_in = 0;
      repeat (4) @(negedge sys_clk);
      chk("master_fault_flag_sw", 8'h00, master_fault_flag);
      n_irq = 0;
      slave_select_software_mode = 0;
      repeat (4) @(negedge sys_clk);
      chk("master_fault_flag", 8'h04, {master_fault_flag, port_enabled,
         master_active});
      chk("master_fault_flag_irq", 8'h01, n_irq[7:0]);
      ss_n_in = 1;
      ctl(1'h1, 1'h0);
      chk("locked", 8'h00, port_enabled);
      status_rd = 1;
      @(negedge sys_clk) status_rd = 0;
      ctl(1'h1, 1'h0);
      chk("unlock", 8'h01, {master_fault_flag, port_enabled});
      $display("test fault done");
   endtask

   task automatic t_slave;
      logic [7:0] got;
      logic [7:0] b;
      b = 8'h96;
      wr(8'hc3);
      @(negedge sys_clk);
      chk("miso_oe", 8'h00, miso_oe);
      ss_n_in = 0;
      for (int i = 7; i >= 0; i--) begin
         m_mosi = b[i];
         m_sck = 0;
         repeat (4) @(negedge sys_clk);
         got[i] = miso_out;
         m_sck = 1;
         repeat (4) @(negedge sys_clk);
      end
      m_sck = 0;
      repeat (8) @(negedge sys_clk);
      chk("s_tx", 8'hc3, got);
      chk("s_rx", 8'h96, data_rdata);
      chk("s_oe", 8'h03, {transfer_complete_flag, miso_oe});
      clr();
      wr(8'h55);
      @(negedge sys_clk);
      chk("s_write_collision_flag", 8'h01, write_collision_flag);
      ss_n_in = 1;
      repeat (4) @(negedge sys_clk);
      chk("s_off", 8'h00, miso_oe);
      $display("test slave done");
   endtask

   // second-edge slave, idle-high clock, select low by software level
   task automatic t_slave_ph1;
      logic [7:0] got;
      logic [7:0] b;
      b = 8'h2d;
      clr();
      slave_select_software_mode = 1;
      internal_select_level = 1;
      clk_pol = 1;
      clk_pha = 1;
      m_sck = 1;
      repeat (4) @(negedge sys_clk);
      wr(8'h69);
      internal_select_level = 0;
      for (int i = 7; i >= 0; i--) begin
         m_sck = 0;
         m_mosi = b[i];
         repeat (4) @(negedge sys_clk);
         got[i] = miso_out;
         m_sck = 1;
         repeat (4) @(negedge sys_clk);
      end
      repeat (4) @(negedge sys_clk);
      chk("p1_tx", 8'h69, got);
      chk("p1_rx", 8'h2d, data_rdata);
      chk("p1_oe", 8'h03, {transfer_complete_flag, miso_oe});
      chk("p1_busy", 8'h00, busy);
      internal_select_level = 1;
      repeat (2) @(negedge sys_clk);
      chk("p1_off", 8'h00, miso_oe);
      $display("test slave phase 1 done");
   endtask

   task automatic summarize;
      $display("tests %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // reset for five cycles, then the scenarios in order
   initial begin
      repeat (5) @(negedge sys_clk);
      nrst = 1;
      @(negedge sys_clk);
      chk("reset", 8'h00, {transfer_complete_flag, write_collision_flag,
         master_fault_flag, overrun_flag, port_enabled, busy, irq});
      t_master();
      t_rates();
      t_fault();
      t_slave();
      t_slave_ph1();
      summarize();
   end
endmodule
